// ==== hw/nvc_cfg.svh ====
// Constants of the configuration-save block: offsets, fields, defaults, timing
`ifndef NVC_CFG_SVH
`define NVC_CFG_SVH
`define NVC_CLK_NS        10
`define NVC_NVM_BYTE_NS   2000
`define NVC_NVM_BYTE_CYC  ((`NVC_NVM_BYTE_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_NREG          27
`define NVC_REG_BYPASS    8'h03
`define NVC_BIT_BYPASS    6
`define NVC_REG_STATUS    8'h18
`define NVC_REG_SPREAD    8'h19
`define NVC_REG_COMMIT    8'h1a
`define NVC_BIT_BUSY      7
`define NVC_BIT_LOCK      7
`define NVC_BIT_COMMIT    7
`define NVC_RST_STATUS    8'h38
`define NVC_RST_SPREAD    8'h09
`define NVC_RST_COMMIT    8'h1b
`define NVC_NVM_WIN       8'h80
`define NVC_AV_CTRL       10'h000
`define NVC_AV_STAT       10'h004
`define NVC_AV_IRQ_ST     10'h008
`define NVC_AV_IRQ_MSK    10'h00c
`define NVC_IRQ_DONE      0
`define NVC_IRQ_REFUSED   1
`endif

// ==== hw/nvc_pkg.sv ====
// Types shared by both ends of the configuration-save link
package nvc_pkg;
  typedef enum logic [2:0] {
    NVC_K_RD     = 3'h0,
    NVC_K_WR     = 3'h1,
    NVC_K_BLK    = 3'h2,
    NVC_K_COMMIT = 3'h3,
    NVC_K_SPREAD = 3'h4
  } nvc_kind_t;
  typedef enum logic [1:0] {
    NVC_D_IDLE = 2'h1,
    NVC_D_PROG = 2'h2
  } nvc_dstate_t;
  typedef enum logic [2:0] {
    NVC_H_IDLE = 3'h1,
    NVC_H_POLL = 3'h2,
    NVC_H_XFER = 3'h4
  } nvc_hstate_t;
endpackage

// ==== hw/nvc_if.sv ====
// Register link between the management controller and the clock device
`timescale 1ns/10ps
`default_nettype none
interface nvc_if;
  logic       req;
  logic       wr;
  logic       blk;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic       last;
  logic [7:0] rdata;
  modport dev  (input req, wr, blk, addr, wdata, output ack, last, rdata);
  modport host (output req, wr, blk, addr, wdata, input ack, last, rdata);
endinterface
`default_nettype wire

// ==== hw/nvc_device.sv ====
// Device end: configuration registers, nonvolatile save engine and spread selection
`timescale 1ns/10ps
`default_nettype none
`include "nvc_cfg.svh"
// Contract
// - Busy flag high during save, write-ignored
// - Host sends no writes while busy
// - Reads and block reads answered during save
// - Four-bit code selects modulation divisor
// - Host bypasses loop around spread changes
// - Three-bit depth field selects spread amount
// - Zero depth holds modulated clock low
// - Stored lock refuses all later saves; here a reset clears the lock
// - Only stored lock bit blocks saving
// - Locked device still applies register writes
// - Seven-bit block length, zero refused, default 27
// - Save starts only on commit rising edge
// - Commit bit stays high until cleared
// - Host writes zero then one to commit
// - Host writes commit bit last
// - Host never disturbs running save
module nvc_device #(
  parameter int NVM_BYTE_CYC = `NVC_NVM_BYTE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  nvc_if.dev               link,
  output logic             ssc_mod_clk,
  output logic [2:0]       spread_depth_select,
  output logic [12:0]      spread_rate_div,
  output logic             loop_bypass,
  output logic             nvm_busy_flag,
  output logic             nvm_permanent_lock,
  output logic [6:0]       block_read_length
);
  localparam int NREG = `NVC_NREG;

  logic [7:0]          regs_q [0:NREG-1];
  logic [7:0]          nvm_q  [0:NREG-1];
  nvc_pkg::nvc_dstate_t state_q;
  logic [4:0]          idx_q;
  logic [15:0]         tick_q;
  logic                byte_en;
  logic                acc;
  logic                wr_ok;
  logic                commit_go;
  logic                blk_run_q;
  logic [7:0]          blk_addr_q;
  logic [6:0]          blk_left_q;
  logic [12:0]         mod_cnt_q;

  // Divisor table of the modulation rate selector
  function automatic logic [12:0] rate_div(input logic [3:0] code);
    case (code)
      4'h9:    rate_div = 13'd3286;
      4'ha:    rate_div = 13'd3000;
      4'hb:    rate_div = 13'd2732;
      4'hc:    rate_div = 13'd2464;
      4'hd:    rate_div = 13'd2196;
      4'he:    rate_div = 13'd1928;
      4'hf:    rate_div = 13'd1660;
      default: rate_div = 13'(13'd5680 - 13'd268 * {9'h0, code});
    endcase
  endfunction

  // Upper half of the address space reads back the stored copy
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] o;
    o = 8'h00;
    if (a >= `NVC_NVM_WIN) begin
      if (a - `NVC_NVM_WIN < 8'(NREG))
        o = nvm_q[5'(a - `NVC_NVM_WIN)];
    end else if (a < 8'(NREG)) begin
      o = regs_q[5'(a)];
      if (a == `NVC_REG_STATUS)
        o[`NVC_BIT_BUSY] = nvm_busy_flag;
    end
    rd_byte = o;
  endfunction

  assign acc = link.req && !link.ack && !blk_run_q;
  assign wr_ok = acc && link.wr && !nvm_busy_flag;
  assign commit_go = wr_ok && link.addr == `NVC_REG_COMMIT && link.wdata[`NVC_BIT_COMMIT]
                     && !regs_q[26][`NVC_BIT_COMMIT];
  assign byte_en = (state_q == nvc_pkg::NVC_D_PROG) && tick_q == 16'(NVM_BYTE_CYC - 1);

  // Register file; locked parts still take writes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < NREG; i++)
        regs_q[i] <= 8'h00;
      regs_q[24] <= `NVC_RST_STATUS;
      regs_q[25] <= `NVC_RST_SPREAD;
      regs_q[26] <= `NVC_RST_COMMIT;
    end else if (wr_ok && link.addr < 8'(NREG)) begin
      case (link.addr)
        `NVC_REG_STATUS: regs_q[24] <= {1'b0, link.wdata[6:0]};
        // commit bit cleared by host only
        `NVC_REG_COMMIT: regs_q[26] <= {link.wdata[7],
                                        (link.wdata[6:0] == 7'h00) ? regs_q[26][6:0] : link.wdata[6:0]};
        default:         regs_q[5'(link.addr)] <= link.wdata;
      endcase
    end
  end

  // Save engine; writes are refused meanwhile, so the image is stable
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q       <= nvc_pkg::NVC_D_IDLE;
      idx_q         <= 5'h00;
      tick_q        <= 16'h0000;
      nvm_busy_flag <= 1'b0;
    end else begin
      case (state_q)
        nvc_pkg::NVC_D_IDLE: begin
          if (commit_go && !nvm_permanent_lock) begin
            state_q       <= nvc_pkg::NVC_D_PROG;
            idx_q         <= 5'h00;
            tick_q        <= 16'h0000;
            nvm_busy_flag <= 1'b1;
          end
        end
        nvc_pkg::NVC_D_PROG: begin
          tick_q <= byte_en ? 16'h0000 : 16'(tick_q + 16'h0001);
          if (byte_en) begin
            idx_q <= 5'(idx_q + 5'h01);
            if (idx_q == 5'(NREG - 1)) begin
              state_q       <= nvc_pkg::NVC_D_IDLE;
              nvm_busy_flag <= 1'b0;
            end
          end
        end
        default: state_q <= nvc_pkg::NVC_D_IDLE;
      endcase
    end
  end

  // one byte per enable, in order
  always_ff @(posedge mclk) begin
    if (byte_en)
      nvm_q[idx_q] <= regs_q[idx_q];
  end

  // Lock is only an in-chip flop, so a reset clears it in this model
  always_ff @(posedge mclk) begin
    if (!rst_n)
      nvm_permanent_lock <= 1'b0;
    else if (byte_en && idx_q == 5'(`NVC_REG_SPREAD) && regs_q[25][`NVC_BIT_LOCK])
      nvm_permanent_lock <= 1'b1;
  end

  // Link answers, block reads stream one byte per cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link.ack   <= 1'b0;
      link.last  <= 1'b0;
      link.rdata <= 8'h00;
      blk_run_q  <= 1'b0;
      blk_addr_q <= 8'h00;
      blk_left_q <= 7'h00;
    end else if (acc) begin
      link.ack   <= 1'b1;
      link.rdata <= link.wr ? 8'h00 : rd_byte(link.addr);
      if (link.blk && !link.wr) begin
        link.last  <= regs_q[26][6:0] == 7'h01;
        blk_run_q  <= regs_q[26][6:0] != 7'h01;
        blk_addr_q <= 8'(link.addr + 8'h01);
        blk_left_q <= 7'(regs_q[26][6:0] - 7'h01);
      end else begin
        link.last <= 1'b1;
      end
    end else if (blk_run_q) begin
      link.ack   <= 1'b1;
      link.rdata <= rd_byte(blk_addr_q);
      link.last  <= blk_left_q == 7'h01;
      blk_run_q  <= blk_left_q != 7'h01;
      blk_addr_q <= 8'(blk_addr_q + 8'h01);
      blk_left_q <= 7'(blk_left_q - 7'h01);
    end else begin
      link.ack  <= 1'b0;
      link.last <= 1'b0;
    end
  end

  // Spread settings follow the registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      spread_depth_select <= 3'h0;
      spread_rate_div     <= 13'd3286;
      loop_bypass         <= 1'b0;
      block_read_length   <= 7'h1b;
    end else begin
      spread_depth_select <= regs_q[25][6:4];
      spread_rate_div     <= rate_div(regs_q[25][3:0]);
      loop_bypass         <= regs_q[3][`NVC_BIT_BYPASS];
      block_read_length   <= regs_q[26][6:0];
    end
  end

  // System clock stands in for the loop oscillator here
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mod_cnt_q   <= 13'h0000;
      ssc_mod_clk <= 1'b0;
    end else if (spread_depth_select == 3'h0 || loop_bypass) begin
      mod_cnt_q   <= 13'h0000;
      ssc_mod_clk <= 1'b0;
    end else if (mod_cnt_q >= 13'((spread_rate_div >> 1) - 13'h0001)) begin
      mod_cnt_q   <= 13'h0000;
      ssc_mod_clk <= !ssc_mod_clk;
    end else begin
      mod_cnt_q <= 13'(mod_cnt_q + 13'h0001);
    end
  end
endmodule
`default_nettype wire

// ==== hw/nvc_host.sv ====
// Host end: Avalon-MM command registers driving the device link
`timescale 1ns/10ps
`default_nettype none
`include "nvc_cfg.svh"
module nvc_host (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [9:0]  av_address,
  input  wire logic        av_read,
  input  wire logic        av_write,
  input  wire logic [31:0] av_writedata,
  input  wire logic [3:0]  av_byteenable,
  output logic [31:0]      av_readdata,
  output logic             av_waitrequest,
  output logic             irq,
  nvc_if.host              link
);
  logic [31:0]          ctrl_q;
  logic [1:0]           irq_st_q;
  logic [1:0]           irq_msk_q;
  logic [1:0]           irq_set;
  logic [7:0]           last_rd_q;
  logic                 refused_q;
  logic [6:0]           cnt_q;
  logic [1:0]           step_q;
  logic [7:0]           buf_q [0:127];
  nvc_pkg::nvc_hstate_t state_q;
  nvc_pkg::nvc_kind_t   kind;
  logic                 acc;
  logic                 go;

  assign acc  = (av_read || av_write) && !av_waitrequest;
  assign go   = acc && av_write && av_address == `NVC_AV_CTRL && av_byteenable[0]
                && state_q == nvc_pkg::NVC_H_IDLE;
  assign kind = nvc_pkg::nvc_kind_t'(ctrl_q[2:0]);

  function automatic logic [1:0] nsteps(input nvc_pkg::nvc_kind_t k);
    case (k)
      nvc_pkg::NVC_K_COMMIT: nsteps = 2'd2;
      nvc_pkg::NVC_K_SPREAD: nsteps = 2'd3;
      default:               nsteps = 2'd1;
    endcase
  endfunction

  // Address and data of each write step of a sequence
  function automatic logic [15:0] step_ad(input logic [31:0] c, input logic [1:0] s);
    case (nvc_pkg::nvc_kind_t'(c[2:0]))
      // commit is its own last write
      nvc_pkg::NVC_K_COMMIT: step_ad = {`NVC_REG_COMMIT, s[0], c[22:16]};
      nvc_pkg::NVC_K_SPREAD: step_ad = (s == 2'd1) ? {`NVC_REG_SPREAD, c[23:16]} :
                                       {`NVC_REG_BYPASS, c[31], (s == 2'd0), c[29:24]};
      default:               step_ad = {c[15:8], c[23:16]};
    endcase
  endfunction

  // Answers one cycle after the request, from a flop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      av_waitrequest <= 1'b1;
      av_readdata    <= 32'h0000_0000;
    end else if ((av_read || av_write) && av_waitrequest) begin
      av_waitrequest <= 1'b0;
      if (av_address[9])
        av_readdata <= {24'h0, buf_q[av_address[8:2]]};
      else
        case (av_address)
          `NVC_AV_CTRL:    av_readdata <= ctrl_q;
          `NVC_AV_STAT:    av_readdata <= {9'h0, cnt_q, last_rd_q, 6'h0, refused_q,
                                           state_q != nvc_pkg::NVC_H_IDLE};
          `NVC_AV_IRQ_ST:  av_readdata <= {30'h0, irq_st_q};
          `NVC_AV_IRQ_MSK: av_readdata <= {30'h0, irq_msk_q};
          default:         av_readdata <= 32'h0000_0000;
        endcase
    end else begin
      av_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      ctrl_q <= 32'h0000_0000;
    else if (acc && av_write && av_address == `NVC_AV_CTRL && state_q == nvc_pkg::NVC_H_IDLE)
      for (int b = 0; b < 4; b++)
        if (av_byteenable[b])
          ctrl_q[8*b +: 8] <= av_writedata[8*b +: 8];
  end

  // Set wins over a write-one clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_st_q  <= 2'h0;
      irq_msk_q <= 2'h0;
      irq       <= 1'b0;
    end else begin
      if (acc && av_write && av_byteenable[0] && av_address == `NVC_AV_IRQ_MSK)
        irq_msk_q <= av_writedata[1:0];
      if (acc && av_write && av_byteenable[0] && av_address == `NVC_AV_IRQ_ST)
        irq_st_q <= (irq_st_q & ~av_writedata[1:0]) | irq_set;
      else
        irq_st_q <= irq_st_q | irq_set;
      irq <= |(irq_st_q & irq_msk_q);
    end
  end

  always_comb begin
    irq_set = 2'h0;
    if (link.req && link.ack) begin
      if (state_q == nvc_pkg::NVC_H_POLL && link.rdata[`NVC_BIT_BUSY])
        irq_set = 2'h3;
      else if (state_q == nvc_pkg::NVC_H_XFER && (link.last || !link.blk) &&
               (link.blk || !link.wr || step_q == 2'(nsteps(kind) - 2'd1)))
        irq_set[`NVC_IRQ_DONE] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (link.req && link.ack && state_q == nvc_pkg::NVC_H_XFER && !link.wr)
      buf_q[cnt_q] <= link.rdata;
  end

  // Every write is preceded by a busy poll
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q    <= nvc_pkg::NVC_H_IDLE;
      link.req   <= 1'b0;
      link.wr    <= 1'b0;
      link.blk   <= 1'b0;
      link.addr  <= 8'h00;
      link.wdata <= 8'h00;
      step_q     <= 2'h0;
      cnt_q      <= 7'h00;
      last_rd_q  <= 8'h00;
      refused_q  <= 1'b0;
    end else begin
      case (state_q)
        nvc_pkg::NVC_H_IDLE: begin
          if (go) begin
            step_q    <= 2'h0;
            cnt_q     <= 7'h00;
            refused_q <= 1'b0;
            state_q   <= (av_writedata[2:0] == 3'(nvc_pkg::NVC_K_RD) ||
                          av_writedata[2:0] == 3'(nvc_pkg::NVC_K_BLK)) ? nvc_pkg::NVC_H_XFER
                                                                         : nvc_pkg::NVC_H_POLL;
          end
        end
        nvc_pkg::NVC_H_POLL: begin
          if (!link.req) begin
            link.req  <= 1'b1;
            link.wr   <= 1'b0;
            link.blk  <= 1'b0;
            link.addr <= `NVC_REG_STATUS;
          end else if (link.ack) begin
            link.req <= 1'b0;
            if (link.rdata[`NVC_BIT_BUSY]) begin
              refused_q <= 1'b1;
              state_q   <= nvc_pkg::NVC_H_IDLE;
            end else begin
              state_q <= nvc_pkg::NVC_H_XFER;
            end
          end
        end
        nvc_pkg::NVC_H_XFER: begin
          if (!link.req) begin
            link.req   <= 1'b1;
            link.wr    <= kind != nvc_pkg::NVC_K_RD && kind != nvc_pkg::NVC_K_BLK;
            link.blk   <= kind == nvc_pkg::NVC_K_BLK;
            link.addr  <= (kind == nvc_pkg::NVC_K_RD || kind == nvc_pkg::NVC_K_BLK ||
                           kind == nvc_pkg::NVC_K_WR) ? ctrl_q[15:8] : step_ad(ctrl_q, step_q)[15:8];
            link.wdata <= (kind == nvc_pkg::NVC_K_WR) ? ctrl_q[23:16] : step_ad(ctrl_q, step_q)[7:0];
          end else if (link.ack) begin
            if (!link.wr) begin
              last_rd_q <= link.rdata;
              cnt_q     <= 7'(cnt_q + 7'h01);
            end
            if (!link.blk || link.last) begin
              link.req <= 1'b0;
              if (link.wr && step_q != 2'(nsteps(kind) - 2'd1)) begin
                step_q  <= 2'(step_q + 2'd1);
                state_q <= nvc_pkg::NVC_H_POLL;
              end else begin
                state_q <= nvc_pkg::NVC_H_IDLE;
              end
            end
          end
        end
        default: state_q <= nvc_pkg::NVC_H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/nvc_properties.sv ====
// Link and spread-output properties of the configuration-save pair
`timescale 1ns/10ps
`default_nettype none
`include "nvc_cfg.svh"
module nvc_properties #(
  parameter int NVM_BYTE_CYC = `NVC_NVM_BYTE_CYC
) (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       req,
  input wire logic       wr,
  input wire logic       blk,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic       last,
  input wire logic       ssc_mod_clk,
  input wire logic [2:0] spread_depth_select,
  input wire logic       nvm_busy_flag,
  input wire logic       nvm_permanent_lock,
  input wire logic [6:0] block_read_length
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic        commit_q;
  logic [6:0]  bcnt_q;
  logic [15:0] busy_cnt_q;
  logic        cm_wr;
  // Taken at the edge with req high and ack low; busy there means the write is dropped
  assign cm_wr = req && !ack && wr && addr == `NVC_REG_COMMIT && !nvm_busy_flag;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      commit_q <= 1'b0;
    end else if (cm_wr) begin
      commit_q <= wdata[7];
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || !req) begin
      bcnt_q <= 7'h00;
    end else if (ack && blk) begin
      bcnt_q <= bcnt_q + 7'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || !nvm_busy_flag) begin
      busy_cnt_q <= 16'h0000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 16'h0001;
    end
  end
  save_start_a: assert property (cm_wr && wdata[7] && !commit_q && !nvm_permanent_lock |-> ##[1:4] nvm_busy_flag)
    else $error("save did not start on commit rise");
  save_static_a: assert property (cm_wr && wdata[7] && commit_q |=> !nvm_busy_flag [*4])
    else $error("save started on a steady commit bit");
  lock_refuse_a: assert property (nvm_permanent_lock && !nvm_busy_flag |=> !nvm_busy_flag)
    else $error("save started while locked");
  save_length_a: assert property ($fell(nvm_busy_flag) |-> int'(busy_cnt_q) >= 27 * NVM_BYTE_CYC - 1
    && int'(busy_cnt_q) <= 27 * NVM_BYTE_CYC + 2) else $error("busy length wrong");
  busy_read_a: assert property ($rose(req) && !wr && nvm_busy_flag |=> ack)
    else $error("read not answered during save");
  single_ack_a: assert property ($rose(req) && !blk |=> ack && last ##1 !ack)
    else $error("single access answer wrong");
  no_write_busy_a: assert property ($rose(req) && wr |-> !nvm_busy_flag)
    else $error("write sent during save");
  block_last_a: assert property (ack && blk |-> last == (bcnt_q + 7'h01 == block_read_length))
    else $error("block length wrong");
  length_legal_a: assert property (block_read_length != 7'h00)
    else $error("block length zero");
  spread_off_a: assert property (spread_depth_select == 3'h0 [*2] |-> !ssc_mod_clk)
    else $error("modulated clock active at zero depth");
endmodule
`default_nettype wire

// ==== tb/nvm_commit_and_spread_config_tb.sv ====
// Self-checking bench for the host and device ends of the configuration-save link
`timescale 1ns/10ps
`default_nettype none
`include "nvc_cfg.svh"
module nvm_commit_and_spread_config_tb;
  localparam int NBC = 10;
  int          rate_tab [16] = '{5680, 5412, 5144, 4876, 4608, 4340, 4072, 3804, 3536, 3286, 3000, 2732, 2464, 2196,
                                 1928, 1660};
  logic        mclk, rst_n, av_read, av_write, irq, av_waitrequest;
  logic        ssc_mod_clk, loop_bypass, nvm_busy_flag, nvm_permanent_lock, mlock;
  logic [9:0]  av_address;
  logic [3:0]  av_byteenable;
  logic [31:0] av_writedata, av_readdata, st, r, seed;
  logic [2:0]  spread_depth_select, dep_prev;
  logic [12:0] spread_rate_div;
  logic [6:0]  block_read_length;
  logic [7:0]  mreg [27];
  logic [7:0]  mnvm [27];
  logic [7:0]  a8;
  logic [1:0]  msk;
  int          error_cnt, checks, cyc, n0;
  nvc_if link_if ();
  nvc_device #(.NVM_BYTE_CYC(NBC)) nvc_device_inst (.mclk(mclk), .rst_n(rst_n), .link(link_if.dev),
    .ssc_mod_clk(ssc_mod_clk), .spread_depth_select(spread_depth_select), .spread_rate_div(spread_rate_div),
    .loop_bypass(loop_bypass), .nvm_busy_flag(nvm_busy_flag), .nvm_permanent_lock(nvm_permanent_lock),
    .block_read_length(block_read_length));
  nvc_host nvc_host_inst (.mclk(mclk), .rst_n(rst_n), .av_address(av_address), .av_read(av_read),
    .av_write(av_write), .av_writedata(av_writedata), .av_byteenable(av_byteenable), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .irq(irq), .link(link_if.host));
  nvc_properties #(.NVM_BYTE_CYC(NBC)) nvc_properties_inst (.mclk(mclk), .rst_n(rst_n), .req(link_if.req),
    .wr(link_if.wr), .blk(link_if.blk), .addr(link_if.addr), .wdata(link_if.wdata), .ack(link_if.ack),
    .last(link_if.last), .ssc_mod_clk(ssc_mod_clk), .spread_depth_select(spread_depth_select),
    .nvm_busy_flag(nvm_busy_flag), .nvm_permanent_lock(nvm_permanent_lock), .block_read_length(block_read_length));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task test_done();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      test_done();
    end
  end
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Depth may only move while the loop is bypassed
  always @(posedge mclk) begin
    if (rst_n === 1'b1 && spread_depth_select !== dep_prev) cmp("bypass", 1, loop_bypass);
    dep_prev <= spread_depth_select;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task av(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    av_address <= a;
    av_writedata <= d;
    av_write <= w;
    av_read <= !w;
    // Only the bench timeout ends this wait
    do begin
      @(posedge mclk);
    end while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av_write <= 1'b0;
    av_read <= 1'b0;
    @(posedge mclk);
  endtask
  task op(input nvc_pkg::nvc_kind_t k, input logic [7:0] a, input logic [7:0] d, input logic [7:0] b,
          output logic [31:0] s);
    logic [31:0] q;
    av(1'b1, `NVC_AV_CTRL, {b, d, a, 5'h00, k}, q);
    q = 32'h0;
    while (q[0] !== 1'b1) begin
      av(1'b0, `NVC_AV_IRQ_ST, 32'h0, q);
    end
    cmp("irq", |(q[1:0] & msk), irq);
    av(1'b1, `NVC_AV_IRQ_ST, q, s);
    av(1'b0, `NVC_AV_STAT, 32'h0, s);
    cmp("irq_clear", 0, irq);
  endtask
  task save();
    op(nvc_pkg::NVC_K_COMMIT, 8'h00, 8'h7f, 8'h00, st);
    mreg[26] = 8'hff;
    if (!mlock) begin
      mnvm = mreg;
      mlock = mreg[25][7];
    end
  endtask
  task wait_idle();
    int n;
    n = 0;
    while (nvm_busy_flag !== 1'b0 && n < 27 * NBC + 100) begin
      @(posedge mclk);
      n++;
    end
    cmp("busy_end", 0, nvm_busy_flag);
  endtask
  initial begin
    {av_read, av_write, av_address, av_writedata, rst_n, mlock, dep_prev} = '0;
    {error_cnt, checks, cyc} = '0;
    av_byteenable = 4'hf;
    seed = 32'd64892;
    msk = 2'h0;
    foreach (mreg[i]) mreg[i] = 8'h00;
    mreg[24] = 8'h38;
    mreg[25] = 8'h09;
    mreg[26] = 8'h1b;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    cmp("depth", 0, spread_depth_select);
    cmp("rate_div", 3286, spread_rate_div);
    cmp("length", 27, block_read_length);
    for (int i = 24; i < 27; i++) begin
      op(nvc_pkg::NVC_K_RD, 8'(i), 8'h00, 8'h00, st);
      cmp("reset_reg", mreg[i], st[15:8]);
    end
    av(1'b1, 10'h100, 32'hffffffff, r);
    av(1'b0, 10'h100, 32'h0, r);
    cmp("unmapped", 0, r);
    av(1'b1, `NVC_AV_IRQ_MSK, 32'h3, r);
    msk = 2'h3;
    for (int i = 0; i < 6; i++) begin
      r = xs();
      a8 = 8'h04 + 8'(r[15:8] % 20);
      op(nvc_pkg::NVC_K_WR, a8, r[7:0], 8'h00, st);
      mreg[a8] = r[7:0];
    end
    op(nvc_pkg::NVC_K_WR, 8'h1a, 8'h7f, 8'h00, st);
    mreg[26] = 8'h7f;
    op(nvc_pkg::NVC_K_WR, 8'h1a, 8'h00, 8'h00, st);
    cmp("length_zero", 127, block_read_length);
    op(nvc_pkg::NVC_K_BLK, 8'h00, 8'h00, 8'h00, st);
    cmp("blk_count", 127, st[22:16]);
    for (int i = 0; i < 127; i++) begin
      av(1'b0, 10'h200 + 10'(4 * i), 32'h0, r);
      cmp("blk_byte", (i < 27) ? mreg[i] : 8'h00, r[7:0]);
    end
    for (int c = 0; c < 16; c++) begin
      r = xs();
      mreg[3] = r[7:0] & 8'hbf;
      mreg[25] = {1'b0, 3'(c), 4'(c)};
      op(nvc_pkg::NVC_K_SPREAD, 8'h00, mreg[25], mreg[3], st);
      cmp("depth", c % 8, spread_depth_select);
      cmp("rate_div", rate_tab[c], spread_rate_div);
      for (int k = 0; k < 8 && c % 8 == 0; k++) begin
        @(posedge mclk);
        cmp("ssc_low", 0, ssc_mod_clk);
      end
    end
    // Last code is 15 at depth 7: one modulation period spans the divisor in clocks
    @(posedge ssc_mod_clk);
    n0 = cyc;
    @(posedge ssc_mod_clk);
    cmp("ssc_period", rate_tab[15], cyc - n0);
    op(nvc_pkg::NVC_K_WR, 8'h18, 8'hff, 8'h00, st);
    mreg[24] = 8'h7f;
    cmp("busy_ro", 0, nvm_busy_flag);
    save();
    cmp("busy", 1, nvm_busy_flag);
    op(nvc_pkg::NVC_K_RD, 8'h18, 8'h00, 8'h00, st);
    cmp("busy_read", 8'hff, st[15:8]);
    op(nvc_pkg::NVC_K_WR, 8'h05, 8'h5a, 8'h00, st);
    cmp("refused", 1, st[1]);
    wait_idle();
    op(nvc_pkg::NVC_K_RD, 8'h1a, 8'h00, 8'h00, st);
    cmp("commit_kept", 8'hff, st[15:8]);
    op(nvc_pkg::NVC_K_WR, 8'h1a, 8'hff, 8'h00, st);
    cmp("static_commit", 0, nvm_busy_flag);
    for (int i = 0; i < 27; i++) begin
      op(nvc_pkg::NVC_K_RD, 8'h80 + 8'(i), 8'h00, 8'h00, st);
      cmp("stored", mnvm[i] & ((i == 24) ? 8'h7f : 8'hff), st[15:8] & ((i == 24) ? 8'h7f : 8'hff));
    end
    av(1'b1, `NVC_AV_IRQ_MSK, 32'h0, r);
    msk = 2'h0;
    mreg[25] = mreg[25] | 8'h80;
    op(nvc_pkg::NVC_K_WR, 8'h19, mreg[25], 8'h00, st);
    cmp("lock_volatile", 0, nvm_permanent_lock);
    save();
    cmp("busy", 1, nvm_busy_flag);
    wait_idle();
    cmp("lock", 1, nvm_permanent_lock);
    mreg[25] = mreg[25] & 8'h7f;
    op(nvc_pkg::NVC_K_WR, 8'h19, mreg[25], 8'h00, st);
    save();
    cmp("locked_save", 0, nvm_busy_flag);
    op(nvc_pkg::NVC_K_RD, 8'h99, 8'h00, 8'h00, st);
    cmp("stored_lock", mnvm[25], st[15:8]);
    op(nvc_pkg::NVC_K_WR, 8'h1a, 8'h09, 8'h00, st);
    cmp("locked_write", 9, block_read_length);
    test_done();
  end
endmodule
`default_nettype wire
